/* design/fpio_port_ctrl.sv */
// Four bidirectional ports, 25 lines, reached as data memory locations.
// Assumes the processor drives cpuBus and secondPhaseEdge on ref_clk;
// padIn comes from pins and is synchronised here.
//
// Overview of operation
// - Four ports, 25 lines, latches at 12H..18H
// - Pad sampled unlatched at second phase edge
// - Output latch holds until rewritten
// - Direction bit one input, zero push-pull output
// - Read gives pad if input, else latch
// - Direction registers at 13H..19H above data
// - Reset makes every line an input
// - Bit set and clear change one output bit; latch bits of input lines take the pad value
// - Bit operations read whole port then write
// - Port A lines optionally wake the device
// - Port D upper seven bits absent, read zero
// - Pull-ups per port A-C, one bit D
// - Lines A0, A1, A2 feed interrupts, timer
// - Interrupt trigger off, rise, fall or both
`timescale 1ns/1ps
module fpio_port_ctrl #(
  parameter logic [7:0]           WAKE_MASK = 8'h00,
  parameter logic [3:0]           PULL_OPT  = 4'h0,
  parameter fpio_pkg::fpio_trig_t IRQ0_TRIG = fpio_pkg::TRIG_OFF,
  parameter fpio_pkg::fpio_trig_t IRQ1_TRIG = fpio_pkg::TRIG_OFF
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire fpio_pkg::fpio_bus_t               cpuBus,
  input  wire logic                              secondPhaseEdge,
  input  wire logic [fpio_pkg::LINE_CNT-1:0]     padIn,
  output logic      [7:0]                        dmRdData,
  output logic      [fpio_pkg::LINE_CNT-1:0]     padOut,
  output logic      [fpio_pkg::LINE_CNT-1:0]     padOe,
  output logic      [fpio_pkg::LINE_CNT-1:0]     pullUpEn,
  output logic                                   wakeReq,
  output logic                                   extIrqZero,
  output logic                                   extIrqOne,
  output logic                                   timerEventInput
);

  fpio_pkg::fpio_state_t     state_r;
  fpio_pkg::fpio_state_t     state_nxt;
  logic [3:0][7:0]           padVec;
  logic [3:0][7:0]           portSt;
  logic [3:0][7:0]           pullVec;
  logic [7:0]                regOff;
  logic                      regHit;
  logic                      regIsDir;
  logic [1:0]                regIdx;
  logic [7:0]                opMask;
  logic [7:0]                targetVal;
  logic [7:0]                rmwVal;
  logic                      wrHit;
  logic                      bopHit;
  logic                      rdTake;
  logic [1:0]                irqPulse;

  function automatic logic [24:0] flatPorts(input logic [3:0][7:0] v);
    flatPorts = {v[3][0], v[2], v[1], v[0]};
  endfunction

  // Absent port D pins read as zero so they never leak into a read
  assign padVec = {7'h00, state_r.sync};

  genvar p;
  generate
    for (p = 0; p < fpio_pkg::NUM_PORTS; p++) begin : g_port
      assign portSt[p] = ((state_r.dir[p] & padVec[p])
                         | (~state_r.dir[p] & state_r.latch[p]))
                         & fpio_pkg::PORT_MASK[p];
      assign pullVec[p] = {8{PULL_OPT[p]}};
    end
  endgenerate

  always_comb begin
    regOff = cpuBus.addr - fpio_pkg::PORT_A_DATA;
    regHit = regOff < fpio_pkg::REG_SPAN;
    regIdx = regOff[2:1];
    regIsDir = regOff[0];
    wrHit = cpuBus.wrEn && regHit;
    // A plain write wins if the processor ever asserts both at once
    bopHit = cpuBus.bitOpEn && !cpuBus.wrEn && regHit;
    rdTake = cpuBus.rdEn && secondPhaseEdge;
    opMask = 8'h01 << cpuBus.bitIdx;
    // Whole port state, not the latch, is the operand
    targetVal = regIsDir ? state_r.dir[regIdx] : portSt[regIdx];
    case (cpuBus.bitOp)
      fpio_pkg::BOP_SET: rmwVal = targetVal | opMask;
      fpio_pkg::BOP_CLR: rmwVal = targetVal & ~opMask;
      // Complement acts on the whole byte; bitIdx only steers set/clear
      fpio_pkg::BOP_CPL: rmwVal = ~targetVal;
      default:           rmwVal = targetVal;
    endcase

    state_nxt = state_r;
    state_nxt.meta = padIn;
    state_nxt.sync = state_r.meta;
    state_nxt.prevA = state_r.sync[7:0];

    if (wrHit) begin
      if (regIsDir) begin
        state_nxt.dir[regIdx] = cpuBus.wrData
                                & fpio_pkg::PORT_MASK[regIdx];
      end else begin
        state_nxt.latch[regIdx] = cpuBus.wrData
                                  & fpio_pkg::PORT_MASK[regIdx];
      end
    end else if (bopHit) begin
      if (regIsDir) begin
        state_nxt.dir[regIdx] = rmwVal & fpio_pkg::PORT_MASK[regIdx];
      end else begin
        state_nxt.latch[regIdx] = rmwVal
                                  & fpio_pkg::PORT_MASK[regIdx];
      end
    end

    // Read value is taken only at the phase edge, then held
    if (rdTake) begin
      if (!regHit) begin
        state_nxt.rdData = 8'h00;
      end else if (regIsDir) begin
        state_nxt.rdData = state_r.dir[regIdx];
      end else begin
        state_nxt.rdData = portSt[regIdx];
      end
    end

    state_nxt.oe = ~flatPorts(state_nxt.dir);
    state_nxt.pullEn = flatPorts(pullVec)
                       & flatPorts(state_nxt.dir);
    // Any change on an enabled input line of port A wakes the core
    state_nxt.wake = |(WAKE_MASK & state_r.dir[0]
                       & (state_r.sync[7:0] ^ state_r.prevA));
    state_nxt.tmrEvt = state_r.sync[2];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= '0;
      // Synchroniser runs through reset so no false edge follows it
      state_r.meta <= state_nxt.meta;
      state_r.sync <= state_nxt.sync;
      state_r.prevA <= state_nxt.prevA;
      state_r.latch <= {fpio_pkg::NUM_PORTS{fpio_pkg::LATCH_RESET}};
      state_r.dir <= {fpio_pkg::PORT_MASK[3] & fpio_pkg::DIR_RESET,
                      fpio_pkg::DIR_RESET, fpio_pkg::DIR_RESET,
                      fpio_pkg::DIR_RESET};
      state_r.oe <= '0;
      state_r.pullEn <= flatPorts(pullVec);
    end else begin
      state_r <= state_nxt;
    end
  end

  genvar q;
  generate
    for (q = 0; q < 2; q++) begin : g_irq
      fpio_edge_trig u_edge (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .lineLvl  (state_r.sync[q]),
        .trigSel  ((q == 0) ? IRQ0_TRIG : IRQ1_TRIG),
        .irqPulse (irqPulse[q])
      );
    end
  endgenerate

  assign dmRdData = state_r.rdData;
  assign padOut = flatPorts(state_r.latch);
  assign padOe = state_r.oe;
  assign pullUpEn = state_r.pullEn;
  assign wakeReq = state_r.wake;
  assign extIrqZero = irqPulse[0];
  assign extIrqOne = irqPulse[1];
  assign timerEventInput = state_r.tmrEvt;

  // Unused lines left as inputs float; software is expected to
  // turn them into outputs, the block does not force it.

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  map_write_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_D_DATA)
    |=> padOut[24] == $past(cpuBus.wrData[0]))
    else $error("port D latch write not seen on its line");

  map_port_a_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_A_DATA)
    |=> padOut[7:0] == $past(cpuBus.wrData))
    else $error("port A latch write not seen on its lines");

  read_sample_a: assert property (
    (rdTake && cpuBus.addr == fpio_pkg::PORT_B_DATA)
    |=> dmRdData == $past(portSt[1]))
    else $error("port B read did not take the port state");

  read_hold_a: assert property (
    !rdTake |=> $stable(dmRdData))
    else $error("read data moved without a phase edge read");

  latch_hold_a: assert property (
    !(cpuBus.wrEn || cpuBus.bitOpEn) |=> $stable(padOut) [*1] ##0
    $stable(state_r.latch))
    else $error("output latch changed without a write");

  dir_drive_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_C_DIR)
    |=> padOe[23:16] == ~$past(cpuBus.wrData))
    else $error("port C enables do not follow its direction");

  read_mux_a: assert property (
    (rdTake && cpuBus.addr == fpio_pkg::PORT_A_DATA
      && state_r.dir[0] == 8'h00)
    |=> dmRdData == $past(state_r.latch[0]))
    else $error("output port read did not return the latch");

  read_pad_a: assert property (
    (rdTake && cpuBus.addr == fpio_pkg::PORT_C_DATA
      && state_r.dir[2] == 8'hFF)
    |=> dmRdData == $past(padIn[23:16], 3))
    else $error("input port read did not return the pad");

  dir_map_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_A_DIR)
    |=> state_r.dir[0] == $past(cpuBus.wrData)
        && $stable(state_r.latch))
    else $error("direction write missed or hit the latch");

  reset_input_a: assert property (
    $fell(rst) |-> padOe == '0 && state_r.dir[2] == 8'hFF)
    else $error("a line was not an input after reset");

  bit_only_a: assert property (
    (bopHit && cpuBus.addr == fpio_pkg::PORT_B_DATA
      && cpuBus.bitOp == fpio_pkg::BOP_SET)
    |=> ((state_r.latch[1] ^ $past(state_r.latch[1]))
          & ~$past(opMask) & ~$past(state_r.dir[1])) == 8'h00
        && (state_r.latch[1] & $past(opMask)) != 8'h00)
    else $error("bit set touched another output bit");

  rmw_state_a: assert property (
    (bopHit && cpuBus.addr == fpio_pkg::PORT_C_DATA
      && cpuBus.bitOp == fpio_pkg::BOP_CPL)
    |=> state_r.latch[2] == ~$past(portSt[2]))
    else $error("complement did not use the whole port state");

  wake_src_a: assert property (
    wakeReq |-> (($past(padIn[7:0], 3) ^ $past(padIn[7:0], 4))
                 & WAKE_MASK) != 8'h00)
    else $error("wake without a change on an enabled line");

  timer_pin_a: assert property (
    !$past(rst) |-> timerEventInput == $past(padIn[2], 3))
    else $error("timer input does not follow line A2");

  irq_pin_a: assert property (
    extIrqZero |-> $past(padIn[0], 3) != $past(padIn[0], 4))
    else $error("interrupt zero without an edge on line A0");

  portd_zero_a: assert property (
    (rdTake && cpuBus.addr == fpio_pkg::PORT_D_DATA)
    |=> dmRdData[7:1] == 7'h00 && state_r.latch[3][7:1] == 7'h00)
    else $error("absent port D bits read as non-zero");

  pullup_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_B_DIR)
    |=> pullUpEn[15:8] == ({8{PULL_OPT[1]}} & $past(cpuBus.wrData)))
    else $error("port B pull-ups do not follow option and direction");

  dir_read_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_D_DIR)
    ##1 (rdTake && cpuBus.addr == fpio_pkg::PORT_D_DIR)
    |=> dmRdData == {7'h00, $past(cpuBus.wrData[0], 2)})
    else $error("direction read differs from last write");

  range_read_a: assert property (
    (rdTake && !regHit) |=> dmRdData == 8'h00)
    else $error("read outside the port map gave data");

  range_write_a: assert property (
    (cpuBus.wrEn && !regHit)
    |=> $stable(state_r.latch) && $stable(state_r.dir))
    else $error("write outside the port map changed a register");

  bit_clear_a: assert property (
    (bopHit && cpuBus.addr == fpio_pkg::PORT_A_DATA
      && cpuBus.bitOp == fpio_pkg::BOP_CLR)
    |=> (state_r.latch[0] & $past(opMask)) == 8'h00)
    else $error("bit clear left the selected bit set");

  portd_enable_a: assert property (
    (cpuBus.wrEn && cpuBus.addr == fpio_pkg::PORT_D_DIR)
    |=> padOe[24] == !$past(cpuBus.wrData[0]))
    else $error("port D enable does not follow its direction");

  pull_input_a: assert property (
    (pullUpEn & padOe) == '0)
    else $error("pull-up active on a driven line");

  portd_regs_a: assert property (
    state_r.latch[3][7:1] == 7'h00 && state_r.dir[3][7:1] == 7'h00)
    else $error("absent port D bits were written");

  irq_one_a: assert property (
    extIrqOne |-> $past(padIn[1], 3) != $past(padIn[1], 4))
    else $error("interrupt one without an edge on line A1");

  wake_dir_a: assert property (
    wakeReq |-> ($past(state_r.dir[0]) & WAKE_MASK) != 8'h00)
    else $error("wake from a line that is not an enabled input");

  dir_readback_a: assert property (
    (rdTake && regHit && regIsDir)
    |=> dmRdData == $past(state_r.dir[regIdx]))
    else $error("direction read differs from the register");

  timer_reset_a: assert property (
    $fell(rst) |-> !timerEventInput && !wakeReq)
    else $error("timer or wake output set straight after reset");

  portd_output_a: assert property (
    (rdTake && cpuBus.addr == fpio_pkg::PORT_D_DATA
      && !state_r.dir[3][0])
    |=> dmRdData[0] == $past(state_r.latch[3][0]))
    else $error("port D output read did not return the latch");

  bitop_input_c: cover property (
    bopHit && cpuBus.addr == fpio_pkg::PORT_A_DATA
    && state_r.dir[0] != 8'h00);

  read_port_d_c: cover property (
    rdTake && cpuBus.addr == fpio_pkg::PORT_D_DATA);

  wake_seen_c: cover property (wakeReq);

  irq_seen_c: cover property (extIrqZero || extIrqOne);

  cpl_seen_c: cover property (
    bopHit && cpuBus.bitOp == fpio_pkg::BOP_CPL);

endmodule

/* design/fpio_pkg.sv */
// Constants, types and carriers for the four-port bidirectional I/O block.
// Assumes one 25 MHz clock and a synchronous active-high reset.
package fpio_pkg;

  localparam int unsigned NUM_PORTS = 4;
  localparam int unsigned LINE_CNT  = 25;

  // Data memory map: data latch at even, direction at odd location
  localparam logic [7:0] PORT_A_DATA = 8'h12;
  localparam logic [7:0] PORT_A_DIR  = 8'h13;
  localparam logic [7:0] PORT_B_DATA = 8'h14;
  localparam logic [7:0] PORT_B_DIR  = 8'h15;
  localparam logic [7:0] PORT_C_DATA = 8'h16;
  localparam logic [7:0] PORT_C_DIR  = 8'h17;
  localparam logic [7:0] PORT_D_DATA = 8'h18;
  localparam logic [7:0] PORT_D_DIR  = 8'h19;
  localparam logic [7:0] REG_SPAN    = 8'h08;

  // Values after reset: all lines input, latches cleared
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // Implemented bits per port; port D has a single line
  localparam logic [3:0][7:0] PORT_MASK = {8'h01, 8'hFF, 8'hFF, 8'hFF};

  // Pad timing: cycles from pad to synchronised value
  localparam int unsigned SYNC_CYCLES = 2;

  typedef enum logic [1:0] {
    TRIG_OFF,
    TRIG_RISE,
    TRIG_FALL,
    TRIG_BOTH
  } fpio_trig_t;

  typedef enum logic [1:0] {
    BOP_SET,
    BOP_CLR,
    BOP_CPL
  } fpio_bitop_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wrEn;
    logic [7:0]  wrData;
    logic        rdEn;
    logic        bitOpEn;
    fpio_bitop_t bitOp;
    logic [2:0]  bitIdx;
  } fpio_bus_t;

  typedef struct packed {
    logic [NUM_PORTS-1:0][7:0] latch;
    logic [NUM_PORTS-1:0][7:0] dir;
    logic [LINE_CNT-1:0]       meta;
    logic [LINE_CNT-1:0]       sync;
    logic [7:0]                prevA;
    logic [7:0]                rdData;
    logic [LINE_CNT-1:0]       oe;
    logic [LINE_CNT-1:0]       pullEn;
    logic                      wake;
    logic                      tmrEvt;
  } fpio_state_t;

  typedef struct packed {
    logic armed;
    logic prevLvl;
    logic pulse;
  } fpio_edge_t;

endpackage

/* design/fpio_edge_trig.sv */
// Edge trigger for one external interrupt input shared with a port line.
// Assumes lineLvl is already synchronised to ref_clk.
`timescale 1ns/1ps
module fpio_edge_trig (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 lineLvl,
  input  wire fpio_pkg::fpio_trig_t trigSel,
  output logic                      irqPulse
);

  fpio_pkg::fpio_edge_t st_r;
  fpio_pkg::fpio_edge_t st_nxt;
  logic                 rise;
  logic                 fall;

  always_comb begin
    // No edge is reported until a previous level is known
    rise = st_r.armed & lineLvl & ~st_r.prevLvl;
    fall = st_r.armed & ~lineLvl & st_r.prevLvl;
    st_nxt = st_r;
    st_nxt.armed = 1'b1;
    st_nxt.prevLvl = lineLvl;
    case (trigSel)
      fpio_pkg::TRIG_RISE: st_nxt.pulse = rise;
      fpio_pkg::TRIG_FALL: st_nxt.pulse = fall;
      fpio_pkg::TRIG_BOTH: st_nxt.pulse = rise | fall;
      default:             st_nxt.pulse = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irqPulse = st_r.pulse;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  edge_rise_a: assert property (
    (trigSel == fpio_pkg::TRIG_RISE && st_r.armed && lineLvl
      && !st_r.prevLvl) |=> irqPulse ##1 !irqPulse)
    else $error("rising edge did not give one pulse");

  edge_off_a: assert property (
    trigSel == fpio_pkg::TRIG_OFF |-> ##1 !irqPulse)
    else $error("disabled trigger gave a pulse");

  edge_fall_a: assert property (
    (trigSel == fpio_pkg::TRIG_FALL && $rose(lineLvl)) |=> !irqPulse)
    else $error("falling trigger fired on a rise");

endmodule

/* testbench/fpio_pad_model.sv */
// Pin-side model: external drivers, pull-ups and floating lines.
// Assumes the bench sets extEn/extVal and the design drives padOut/padOe.
`timescale 1ns/1ps
module fpio_pad_model (
  input  wire logic        ref_clk,
  input  wire logic [24:0] padOut,
  input  wire logic [24:0] padOe,
  input  wire logic [24:0] pullUpEn,
  input  wire logic [24:0] extVal,
  input  wire logic [24:0] extEn,
  output logic      [24:0] padIn
);
  logic [24:0] floatPat = 25'h0AAAAAA;
  // Undriven lines wander so that no read can count on them
  always @(posedge ref_clk) floatPat <= ~floatPat;
  always_comb begin
    for (int i = 0; i < 25; i++) begin
      if (padOe[i])
        padIn[i] = padOut[i];
      else if (extEn[i])
        padIn[i] = extVal[i];
      else if (pullUpEn[i])
        padIn[i] = 1'b1;
      else
        padIn[i] = floatPat[i];
    end
  end
endmodule

/* testbench/four_port_bidirectional_io_tb.sv */
// Self-checking bench for the four-port I/O block.
// Assumes the pad model stands on the pins; reads are checked from a queue.
`timescale 1ns/1ps
module four_port_bidirectional_io_tb;
  localparam logic [3:0] PU = 4'h5;
  logic                ref_clk, rst, spe, took;
  fpio_pkg::fpio_bus_t cpuBus;
  logic [24:0]         padIn, padOut, padOe, pullUpEn, extVal, extEn;
  logic [7:0]          dmRdData;
  logic                wakeReq, irq0, irq1, tmrIn;
  logic [7:0]          expQ[$];
  logic [7:0]          lat[4], dir[4];
  int num_errors, comparisons, cycles, irq0Cnt, irq1Cnt, wakeCnt;
  int c0, c1, cw;

  fpio_port_ctrl #(.WAKE_MASK(8'h0F), .PULL_OPT(PU),
    .IRQ0_TRIG(fpio_pkg::TRIG_RISE), .IRQ1_TRIG(fpio_pkg::TRIG_BOTH)) uut (
    .ref_clk(ref_clk), .rst(rst), .cpuBus(cpuBus), .secondPhaseEdge(spe),
    .padIn(padIn), .dmRdData(dmRdData), .padOut(padOut), .padOe(padOe),
    .pullUpEn(pullUpEn), .wakeReq(wakeReq), .extIrqZero(irq0),
    .extIrqOne(irq1), .timerEventInput(tmrIn));
  fpio_pad_model pads (.ref_clk(ref_clk), .padOut(padOut), .padOe(padOe),
    .pullUpEn(pullUpEn), .extVal(extVal), .extEn(extEn), .padIn(padIn));

  initial begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic chk(string what, logic [24:0] e, logic [24:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard; the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  always @(posedge ref_clk) begin
    took <= cpuBus.rdEn && spe;
    irq0Cnt += (irq0 === 1'b1);
    irq1Cnt += (irq1 === 1'b1);
    wakeCnt += (wakeReq === 1'b1);
  end
  always @(negedge ref_clk) if (took === 1'b1) begin
    if (expQ.size() == 0)
      chk("read queue", 25'h1, 25'h0);
    else
      chk("dmRdData", 25'(expQ.pop_front()), 25'(dmRdData));
  end

  task automatic acc(logic [7:0] a, logic w, logic [7:0] d, logic r,
                     logic b, fpio_pkg::fpio_bitop_t op, logic [2:0] i);
    @(posedge ref_clk);
    cpuBus <= '{addr:a, wrEn:w, wrData:d, rdEn:r, bitOpEn:b, bitOp:op,
                bitIdx:i};
    spe <= r;
  endtask

  task automatic idle(int n);
    acc(8'h00, 0, 8'h00, 0, 0, fpio_pkg::BOP_SET, 3'd0);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [7:0] st(int p);
    return ((lat[p] & ~dir[p]) | (extVal[p*8+:8] & dir[p]))
           & fpio_pkg::PORT_MASK[p];
  endfunction

  task automatic wr(int p, logic dsel, logic [7:0] d);
    acc(8'h12 + 8'(2*p) + 8'(dsel), 1, d, 0, 0, fpio_pkg::BOP_SET, 3'd0);
    if (dsel) dir[p] = d & fpio_pkg::PORT_MASK[p];
    else lat[p] = d & fpio_pkg::PORT_MASK[p];
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    acc(a, 0, 8'h00, 1, 0, fpio_pkg::BOP_SET, 3'd0);
    expQ.push_back(e);
  endtask

  task automatic bop(int p, fpio_pkg::fpio_bitop_t op, logic [2:0] i);
    logic [7:0] v;
    v = st(p);
    acc(8'h12 + 8'(2*p), 0, 8'h00, 0, 1, op, i);
    case (op)
      fpio_pkg::BOP_SET: v = v | (8'h01 << i);
      fpio_pkg::BOP_CLR: v = v & ~(8'h01 << i);
      default:           v = ~v;
    endcase
    lat[p] = v & fpio_pkg::PORT_MASK[p];
  endtask

  initial begin
    rst = 1;
    spe = 0;
    cpuBus = '0;
    extVal = '0;
    extEn = '0;
    cycles = 0;
    void'($urandom(32'h2F0E));
    for (int p = 0; p < 4; p++) begin
      lat[p] = 8'h00;
      dir[p] = fpio_pkg::PORT_MASK[p];
    end
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    idle(4);
    chk("padOe", 25'h0, padOe);
    chk("pullUpEn", 25'h0FF00FF, pullUpEn);
    rd(fpio_pkg::PORT_A_DATA, 8'hFF);
    rd(fpio_pkg::PORT_C_DATA, 8'hFF);
    for (int p = 0; p < 4; p++) rd(8'h13 + 8'(2*p), dir[p]);
    rd(8'h1A, 8'h00);
    rd(8'h11, 8'h00);
    idle(2);
    // Random latches and directions with every pin externally driven
    extEn <= '1;
    extVal <= 25'($urandom);
    for (int p = 0; p < 4; p++) begin
      wr(p, 0, 8'($urandom));
      wr(p, 1, 8'($urandom));
    end
    acc(8'h1A, 1, 8'hFF, 0, 0, fpio_pkg::BOP_SET, 3'd0);
    idle(4);
    chk("padOut", {lat[3][0], lat[2], lat[1], lat[0]}, padOut);
    chk("padOe", ~{dir[3][0], dir[2], dir[1], dir[0]}, padOe);
    chk("pullUpEn", {1'b0, dir[2], 8'h00, dir[0]}, pullUpEn);
    for (int p = 0; p < 4; p++) begin
      rd(8'h12 + 8'(2*p), st(p));
      rd(8'h13 + 8'(2*p), dir[p]);
    end
    rd(8'h1A, 8'h00);
    for (int k = 0; k < 3; k++)
      for (int p = 0; p < 4; p++)
        bop(p, fpio_pkg::fpio_bitop_t'(k), 3'($urandom));
    idle(2);
    chk("padOut", {lat[3][0], lat[2], lat[1], lat[0]}, padOut);
    rd(fpio_pkg::PORT_D_DATA, st(3));
    // Shared port A lines: interrupts, timer input, wake-up
    wr(0, 1, 8'hFF);
    @(posedge ref_clk) extVal[7:0] <= 8'h00;
    idle(6);
    c0 = irq0Cnt;
    c1 = irq1Cnt;
    cw = wakeCnt;
    @(posedge ref_clk) extVal[7:0] <= 8'h0F;
    idle(6);
    chk("extIrqZero", 25'(c0 + 1), 25'(irq0Cnt));
    chk("extIrqOne", 25'(c1 + 1), 25'(irq1Cnt));
    chk("timerEventInput", 25'h1, 25'(tmrIn));
    chk("wakeReq", 25'(cw + 1), 25'(wakeCnt));
    @(posedge ref_clk) extVal[7:0] <= 8'h80;
    idle(6);
    @(posedge ref_clk) extVal[7:0] <= 8'h00;
    idle(6);
    chk("extIrqZero", 25'(c0 + 1), 25'(irq0Cnt));
    chk("extIrqOne", 25'(c1 + 2), 25'(irq1Cnt));
    chk("timerEventInput", 25'h0, 25'(tmrIn));
    chk("wakeReq", 25'(cw + 2), 25'(wakeCnt));
    wr(3, 1, 8'h00);
    idle(3);
    wr(3, 1, 8'hFF);
    rd(fpio_pkg::PORT_D_DIR, dir[3]);
    idle(2);
    // Second reset in mid-run: lines fall back to inputs, latches clear
    @(posedge ref_clk) rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      lat[p] = 8'h00;
      dir[p] = fpio_pkg::PORT_MASK[p];
    end
    idle(2);
    chk("padOe", 25'h0, padOe);
    chk("padOut", 25'h0, padOut);
    rd(fpio_pkg::PORT_B_DIR, 8'hFF);
    idle(2);
    wrap_up();
  end
endmodule
